// ===== core/lpmt_pkg.sv
// constants, field layout and types of the local-to-pci master translator
// assumes one clock for the pci side, the local side and the register port
package lpmt_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_REMAP = 8'h28;
	localparam logic [7:0] OFS_CFGA = 8'h2c;
	localparam logic [7:0] OFS_SP1 = 8'hf0;
	localparam logic [31:0] RST_ZERO = 32'h0;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int REMAP_LSB = 16;
	localparam int REMAP_W = 16;
	localparam int DLY_LSB = 14;
	localparam int DLY_W = 2;
	localparam int IOSEL_BIT = 13;
	localparam int LOWCTL_W = 13;
	localparam int CFG_EN_BIT = 31;
	localparam int BUS_LSB = 16;
	localparam int BUS_W = 8;
	localparam int DEV_LSB = 11;
	localparam int DEV_W = 5;
	localparam int FUNC_LSB = 8;
	localparam int FUNC_W = 3;
	localparam int REGN_LSB = 2;
	localparam int REGN_W = 6;
	localparam int TYPE_W = 2;
	localparam int SP1_IO_BIT = 0;

	// ----------------------------------------
	// codes and counts
	// ----------------------------------------
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	localparam logic [1:0] CFG_TYPE1 = 2'h1;
	localparam logic [1:0] DLY_NONE = 2'h0;
	localparam logic [1:0] DLY_CODE4 = 2'h1;
	localparam logic [1:0] DLY_CODE8 = 2'h2;
	localparam logic [1:0] DLY_CODE16 = 2'h3;
	localparam int CNT_W = 5;
	localparam logic [4:0] DLY_CLK4 = 5'h4;
	localparam logic [4:0] DLY_CLK8 = 5'h8;
	localparam logic [4:0] DLY_CLK16 = 5'h10;
	localparam logic [4:0] CNT_LAST = 5'h1;
	localparam logic [4:0] CNT_ZERO = 5'h0;

	typedef enum logic [1:0] {
		LPMT_MEM = 2'h0,
		LPMT_IO = 2'h1,
		LPMT_CFG0 = 2'h2,
		LPMT_CFG1 = 2'h3
	} lpmt_kind_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_ISSUE = 3'h4
	} lpmt_state_e;
endpackage

// ===== core/lpmt_dly_if.sv
// carrier between the translator and its request-delay counter
// assumes both ends sit on core_clk
`timescale 1ns/1ps
`default_nettype none
interface lpmt_dly_if;
	logic start;
	logic [1:0] code;
	logic done;
	modport ctl (output start, output code, input done);
	modport cnt (input start, input code, output done);
endinterface
`default_nettype wire

// ===== core/lpmt_delay_cnt.sv
// request hold-off counter for burst writes toward pci
// assumes start is a one-cycle pulse from the translator
`timescale 1ns/1ps
`default_nettype none
module lpmt_delay_cnt (
	input wire logic core_clk,
	input wire logic rst_n,
	lpmt_dly_if.cnt dly
);
	typedef struct packed {
		logic [lpmt_pkg::CNT_W-1:0] cnt;
	} lpmt_cnt_s;

	lpmt_cnt_s s_ff;
	lpmt_cnt_s nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (dly.start) begin
			unique case (dly.code)
				lpmt_pkg::DLY_NONE: nxt_s.cnt = lpmt_pkg::CNT_ZERO;
				lpmt_pkg::DLY_CODE4: nxt_s.cnt = lpmt_pkg::DLY_CLK4;
				lpmt_pkg::DLY_CODE8: nxt_s.cnt = lpmt_pkg::DLY_CLK8;
				default: nxt_s.cnt = lpmt_pkg::DLY_CLK16;
			endcase
		end else if (s_ff.cnt != lpmt_pkg::CNT_ZERO) begin
			nxt_s.cnt = s_ff.cnt - lpmt_pkg::CNT_LAST;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// last waiting cycle; the request rises on the next one
	assign dly.done = (s_ff.cnt == lpmt_pkg::CNT_LAST);
endmodule
`default_nettype wire

// ===== core/lpmt_core.sv
// local-to-pci master address translation and configuration cycle builder
// assumes local master, pci side and register port all run on core_clk
// How it works
// - burst writes hold the pci request off 0, 4, 8 or 16 clocks by code
// - upper pci memory address takes remap bits where local bits were decoded
// - type code 00 gives a type 0 cycle, 01 a type 1 cycle
// - type 1 configuration address is built from register, function, device and bus fields
// - with the enable bit set, local i/o accesses become configuration cycles
// - space one decodes as memory when its type bit is 0, i/o when 1
// - with i/o remap select set, i/o accesses drive upper address bits as zero
`timescale 1ns/1ps
`default_nettype none
module lpmt_core (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic lcl_req,
	input wire logic lcl_is_io,
	input wire logic lcl_burst_wr,
	input wire logic [31:0] lcl_addr,
	input wire logic [31:0] mem_range,
	input wire logic [31:0] io_range,
	output logic lcl_ready,
	output logic pci_req,
	input wire logic pci_ack,
	output logic [31:0] pci_addr,
	output logic [1:0] pci_kind,
	input wire logic pci_cyc_is_io,
	output logic sp1_is_io,
	output logic sp1_match
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [lpmt_pkg::REMAP_W-1:0] remap;
		logic [lpmt_pkg::DLY_W-1:0] wr_dly;
		logic io_sel;
		logic [lpmt_pkg::LOWCTL_W-1:0] low_ctl;
		logic cfg_en;
		logic [lpmt_pkg::BUS_W-1:0] bus;
		logic [lpmt_pkg::DEV_W-1:0] dev;
		logic [lpmt_pkg::FUNC_W-1:0] func;
		logic [lpmt_pkg::REGN_W-1:0] regn;
		logic [lpmt_pkg::TYPE_W-1:0] ctype;
		logic [31:0] sp1;
		lpmt_pkg::lpmt_state_e st;
		logic [31:0] addr;
		lpmt_pkg::lpmt_kind_e kind;
		logic [31:0] rdata;
	} lpmt_core_s;

	lpmt_core_s s_ff;
	lpmt_core_s nxt_s;
	logic take;
	logic [31:0] be_mask;
	logic [31:0] remap_word;
	logic [31:0] cfga_word;
	logic [31:0] merged;
	logic [15:0] hi_mem;
	logic [15:0] hi_io;
	logic [31:0] cfg_word;
	logic [31:0] idsel;
	logic [31:0] tr_addr;
	lpmt_pkg::lpmt_kind_e tr_kind;

	lpmt_dly_if dly ();

	lpmt_delay_cnt u_dly (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.dly(dly)
	);

	assign take = lcl_req && lcl_ready;
	assign be_mask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
	assign remap_word = {s_ff.remap, s_ff.wr_dly, s_ff.io_sel, s_ff.low_ctl};
	// reserved 30:24 never stored, so they read zero
	assign cfga_word = {s_ff.cfg_en, 7'h0, s_ff.bus, s_ff.dev, s_ff.func, s_ff.regn, s_ff.ctype};

	// ----------------------------------------
	// address translation
	// ----------------------------------------
	// only decoded bits are replaced; undecoded bits keep the local offset, except i/o with io_sel set, which drives all upper bits zero
	assign hi_mem = (s_ff.remap & mem_range[31:16]) | (lcl_addr[31:16] & ~mem_range[31:16]);
	assign hi_io = s_ff.io_sel ? 16'h0 :
		((s_ff.remap & io_range[31:16]) | (lcl_addr[31:16] & ~io_range[31:16]));
	// type 0 selects the target by a one-hot bit above the function field
	assign idsel = 32'h1 << (lpmt_pkg::DEV_LSB + 32'(s_ff.dev));

	always_comb begin
		cfg_word = '0;
		cfg_word[lpmt_pkg::REGN_LSB +: lpmt_pkg::REGN_W] = s_ff.regn;
		cfg_word[lpmt_pkg::FUNC_LSB +: lpmt_pkg::FUNC_W] = s_ff.func;
		if (s_ff.ctype == lpmt_pkg::CFG_TYPE1) begin
			cfg_word[lpmt_pkg::DEV_LSB +: lpmt_pkg::DEV_W] = s_ff.dev;
			cfg_word[lpmt_pkg::BUS_LSB +: lpmt_pkg::BUS_W] = s_ff.bus;
			cfg_word[1:0] = lpmt_pkg::CFG_TYPE1;
		end else begin
			cfg_word = cfg_word | (idsel & 32'hfffff800);
		end
	end

	always_comb begin
		if (lcl_is_io && s_ff.cfg_en) begin
			tr_addr = cfg_word;
			tr_kind = (s_ff.ctype == lpmt_pkg::CFG_TYPE1) ? lpmt_pkg::LPMT_CFG1 : lpmt_pkg::LPMT_CFG0;
		end else if (lcl_is_io) begin
			tr_addr = {hi_io, lcl_addr[15:0]};
			tr_kind = lpmt_pkg::LPMT_IO;
		end else begin
			tr_addr = {hi_mem, lcl_addr[15:0]};
			tr_kind = lpmt_pkg::LPMT_MEM;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		merged = '0;
		dly.start = 1'b0;
		dly.code = s_ff.wr_dly;
		if (reg_wr && reg_addr == lpmt_pkg::OFS_REMAP) begin
			merged = (remap_word & ~be_mask) | (reg_wdata & be_mask);
			nxt_s.remap = merged[lpmt_pkg::REMAP_LSB +: lpmt_pkg::REMAP_W];
			nxt_s.wr_dly = merged[lpmt_pkg::DLY_LSB +: lpmt_pkg::DLY_W];
			nxt_s.io_sel = merged[lpmt_pkg::IOSEL_BIT];
			nxt_s.low_ctl = merged[lpmt_pkg::LOWCTL_W-1:0];
		end else if (reg_wr && reg_addr == lpmt_pkg::OFS_CFGA) begin
			merged = (cfga_word & ~be_mask) | (reg_wdata & be_mask);
			nxt_s.cfg_en = merged[lpmt_pkg::CFG_EN_BIT];
			nxt_s.bus = merged[lpmt_pkg::BUS_LSB +: lpmt_pkg::BUS_W];
			nxt_s.dev = merged[lpmt_pkg::DEV_LSB +: lpmt_pkg::DEV_W];
			nxt_s.func = merged[lpmt_pkg::FUNC_LSB +: lpmt_pkg::FUNC_W];
			nxt_s.regn = merged[lpmt_pkg::REGN_LSB +: lpmt_pkg::REGN_W];
			nxt_s.ctype = merged[lpmt_pkg::TYPE_W-1:0];
		end else if (reg_wr && reg_addr == lpmt_pkg::OFS_SP1) begin
			nxt_s.sp1 = (s_ff.sp1 & ~be_mask) | (reg_wdata & be_mask);
		end
		if (reg_rd) begin
			unique case (reg_addr)
				lpmt_pkg::OFS_REMAP: nxt_s.rdata = remap_word;
				lpmt_pkg::OFS_CFGA: nxt_s.rdata = cfga_word;
				lpmt_pkg::OFS_SP1: nxt_s.rdata = s_ff.sp1;
				default: nxt_s.rdata = lpmt_pkg::RST_ZERO;
			endcase
		end
		unique case (s_ff.st)
			lpmt_pkg::ST_IDLE: begin
				if (take) begin
					nxt_s.addr = tr_addr;
					nxt_s.kind = tr_kind;
					if (lcl_burst_wr && s_ff.wr_dly != lpmt_pkg::DLY_NONE) begin
						dly.start = 1'b1;
						nxt_s.st = lpmt_pkg::ST_WAIT;
					end else begin
						nxt_s.st = lpmt_pkg::ST_ISSUE;
					end
				end
			end
			lpmt_pkg::ST_WAIT: begin
				if (dly.done) begin
					nxt_s.st = lpmt_pkg::ST_ISSUE;
				end
			end
			lpmt_pkg::ST_ISSUE: begin
				if (pci_ack) begin
					nxt_s.st = lpmt_pkg::ST_IDLE;
				end
			end
			default: nxt_s.st = lpmt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.st <= lpmt_pkg::ST_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign lcl_ready = (s_ff.st == lpmt_pkg::ST_IDLE);
	assign pci_req = (s_ff.st == lpmt_pkg::ST_ISSUE);
	assign pci_addr = s_ff.addr;
	assign pci_kind = s_ff.kind;
	assign reg_rdata = s_ff.rdata;
	assign sp1_is_io = s_ff.sp1[lpmt_pkg::SP1_IO_BIT];
	assign sp1_match = (pci_cyc_is_io == s_ff.sp1[lpmt_pkg::SP1_IO_BIT]);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_no_delay;
		take && !(lcl_burst_wr && s_ff.wr_dly != lpmt_pkg::DLY_NONE) |=> pci_req;
	endproperty
	a_no_delay: assert property (p_no_delay) else $error("request not raised at once");

	property p_delay4;
		take && lcl_burst_wr && s_ff.wr_dly == lpmt_pkg::DLY_CODE4 |=> !pci_req [*4] ##1 pci_req;
	endproperty
	a_delay4: assert property (p_delay4) else $error("four clock hold-off wrong");

	property p_delay16;
		take && lcl_burst_wr && s_ff.wr_dly == lpmt_pkg::DLY_CODE16 |=> ##15 !pci_req ##1 pci_req;
	endproperty
	a_delay16: assert property (p_delay16) else $error("sixteen clock hold-off wrong");

	property p_mem_remap;
		take && !lcl_is_io |=> pci_kind == lpmt_pkg::LPMT_MEM &&
			pci_addr[31:16] == (($past(s_ff.remap) & $past(mem_range[31:16])) |
			($past(lcl_addr[31:16]) & ~$past(mem_range[31:16])));
	endproperty
	a_mem_remap: assert property (p_mem_remap) else $error("memory remap wrong");

	property p_cfg1;
		take && lcl_is_io && s_ff.cfg_en && s_ff.ctype == lpmt_pkg::CFG_TYPE1 |=>
			pci_kind == lpmt_pkg::LPMT_CFG1 &&
			pci_addr == {8'h0, $past(s_ff.bus), $past(s_ff.dev), $past(s_ff.func), $past(s_ff.regn), 2'h1};
	endproperty
	a_cfg1: assert property (p_cfg1) else $error("type 1 address wrong");

	property p_cfg0;
		take && lcl_is_io && s_ff.cfg_en && s_ff.ctype == lpmt_pkg::CFG_TYPE0 |=>
			pci_kind == lpmt_pkg::LPMT_CFG0 && pci_addr[1:0] == 2'h0;
	endproperty
	a_cfg0: assert property (p_cfg0) else $error("type 0 cycle wrong");

	property p_io_zero;
		take && lcl_is_io && !s_ff.cfg_en && s_ff.io_sel |=>
			pci_kind == lpmt_pkg::LPMT_IO && pci_addr[31:16] == 16'h0;
	endproperty
	a_io_zero: assert property (p_io_zero) else $error("i/o upper bits not zero");

	property p_cfg_en;
		take && lcl_is_io && s_ff.cfg_en |=> pci_kind inside {lpmt_pkg::LPMT_CFG0, lpmt_pkg::LPMT_CFG1};
	endproperty
	a_cfg_en: assert property (p_cfg_en) else $error("i/o not converted");

	property p_rsv;
		reg_rd && reg_addr == lpmt_pkg::OFS_CFGA |=> reg_rdata[30:24] == 7'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

	property p_sp1;
		reg_wr && reg_addr == lpmt_pkg::OFS_SP1 && reg_be[0] |=>
			sp1_is_io == $past(reg_wdata[lpmt_pkg::SP1_IO_BIT]) &&
			sp1_match == (pci_cyc_is_io == $past(reg_wdata[lpmt_pkg::SP1_IO_BIT]));
	endproperty
	a_sp1: assert property (p_sp1) else $error("space one type decode wrong");

	property p_req_hold;
		pci_req && !pci_ack |=> pci_req && $stable(pci_addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped early");
endmodule
`default_nettype wire

// ===== verif/lpmt_pci_tgt.sv
// pci target model: acknowledges each pci request after a set latency
// assumes pci_req stays high until the edge where pci_ack is seen
`timescale 1ns/1ps
`default_nettype none
module lpmt_pci_tgt (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pci_req,
	input wire logic [3:0] lat,
	output logic pci_ack
);
	logic [3:0] wait_cnt;
	// falling edge drive, so the core samples a settled ack
	always @(negedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 4'h0;
			pci_ack <= 1'b0;
		end else begin
			pci_ack <= (pci_req === 1'b1) && (wait_cnt == lat);
			wait_cnt <= (pci_req === 1'b1) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ===== verif/lpmt_core_test.sv
// self-checking bench for the local-to-pci master translator
// assumes lpmt_core, its delay counter and lpmt_pci_tgt are compiled first
`timescale 1ns/1ps
`default_nettype none
module lpmt_core_test;
	logic core_clk, rst_n, reg_wr, reg_rd, lcl_req, lcl_is_io, lcl_burst_wr;
	logic lcl_ready, pci_req, pci_ack, pci_cyc_is_io, sp1_is_io, sp1_match;
	logic [7:0] reg_addr;
	logic [3:0] reg_be, lat;
	logic [31:0] reg_wdata, reg_rdata, lcl_addr, mem_range, io_range, pci_addr;
	logic [1:0] pci_kind;
	int err_total, check_count;

	lpmt_core uut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.lcl_req(lcl_req), .lcl_is_io(lcl_is_io), .lcl_burst_wr(lcl_burst_wr),
		.lcl_addr(lcl_addr), .mem_range(mem_range), .io_range(io_range),
		.lcl_ready(lcl_ready), .pci_req(pci_req), .pci_ack(pci_ack), .pci_addr(pci_addr),
		.pci_kind(pci_kind), .pci_cyc_is_io(pci_cyc_is_io), .sp1_is_io(sp1_is_io),
		.sp1_match(sp1_match));
	lpmt_pci_tgt tgt (.core_clk(core_clk), .rst_n(rst_n), .pci_req(pci_req), .lat(lat),
		.pci_ack(pci_ack));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		reg_be = be;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
	endtask

	// one local access: checks request delay, address, kind and return to idle
	task automatic acc(input logic io, input logic bw, input logic [31:0] a,
		input logic [31:0] ea, input logic [1:0] ek, input int el);
		int n;
		@(negedge core_clk);
		lcl_is_io = io;
		lcl_burst_wr = bw;
		lcl_addr = a;
		lcl_req = 1'b1;
		@(negedge core_clk);
		lcl_req = 1'b0;
		n = 1;
		while (pci_req !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk(n, el);
		chk(pci_addr, ea);
		chk({30'h0, pci_kind}, {30'h0, ek});
		n = 0;
		while (lcl_ready !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk({31'h0, lcl_ready}, 32'h1);
	endtask

	// ----------------------------------------
	// clock, watchdog
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		#(4000 * 25);
		err_total++;
		stop_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, lcl_req, lcl_is_io, lcl_burst_wr, pci_cyc_is_io} = 7'h0;
		reg_addr = 8'h0;
		reg_be = 4'h0;
		reg_wdata = 32'h0;
		lcl_addr = 32'h0;
		lat = 4'h0;
		mem_range = 32'hfff0_0000;
		io_range = 32'hffff_0000;
		err_total = 0;
		check_count = 0;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		rd(8'h28, 32'h0);
		rd(8'h2c, 32'h0);
		rd(8'hf0, 32'h0);
		chk({31'h0, sp1_match}, 32'h1);
		$display("test reset done");
		wr(8'h2c, 32'hffff_ffff, 4'hf);
		rd(8'h2c, 32'h80ff_ffff);
		wr(8'h2c, 32'h0, 4'h1);
		rd(8'h2c, 32'h80ff_ff00);
		wr(8'h40, 32'hffff_ffff, 4'hf);
		rd(8'h40, 32'h0);
		wr(8'h2c, 32'h0, 4'hf);
		$display("test registers done");
		// remap kept a multiple of the 1 MB decoded window
		wr(8'h28, 32'h1230_0000, 4'hf);
		lat = 4'h3;
		acc(1'b0, 1'b0, 32'habc5_6789, 32'h1235_6789, 2'h0, 1);
		lat = 4'h0;
		acc(1'b1, 1'b0, 32'h5555_4321, 32'h1230_4321, 2'h1, 1);
		wr(8'h28, 32'h1230_2000, 4'hf);
		acc(1'b1, 1'b0, 32'h5555_4321, 32'h0000_4321, 2'h1, 1);
		$display("test translate done");
		wr(8'h2c, 32'h805a_1d31, 4'hf);
		acc(1'b1, 1'b0, 32'h0, 32'h005a_1d31, 2'h3, 1);
		wr(8'h2c, 32'h805a_1d30, 4'hf);
		acc(1'b1, 1'b0, 32'h0, 32'h0000_4530, 2'h2, 1);
		wr(8'h2c, 32'h0, 4'hf);
		$display("test config done");
		for (int c = 0; c < 4; c++) begin
			wr(8'h28, {16'h1230, c[1:0], 14'h0}, 4'hf);
			acc(1'b0, 1'b1, 32'habc5_6789, 32'h1235_6789, 2'h0, (c == 0) ? 1 : (4 << (c - 1)) + 1);
		end
		acc(1'b0, 1'b0, 32'habc5_6789, 32'h1235_6789, 2'h0, 1);
		$display("test delay done");
		// reset in the middle of a sixteen clock hold-off must drop the pending request
		wr(8'h28, {16'h1230, 2'h3, 14'h0}, 4'hf);
		@(negedge core_clk);
		lcl_burst_wr = 1'b1;
		lcl_is_io = 1'b0;
		lcl_req = 1'b1;
		@(negedge core_clk);
		lcl_req = 1'b0;
		repeat (3) @(negedge core_clk);
		chk({30'h0, lcl_ready, pci_req}, 32'h0);
		rst_n = 1'b0;
		@(negedge core_clk);
		chk({30'h0, lcl_ready, pci_req}, 32'h2);
		rst_n = 1'b1;
		repeat (20) @(negedge core_clk);
		chk({30'h0, lcl_ready, pci_req}, 32'h2);
		rd(8'h28, 32'h0);
		$display("test mid-run reset done");
		for (int i = 0; i < 4; i++) begin
			wr(8'hf0, {31'h0, i[1]}, 4'hf);
			pci_cyc_is_io = i[0];
			@(negedge core_clk);
			chk({31'h0, sp1_is_io}, {31'h0, i[1]});
			chk({31'h0, sp1_match}, {31'h0, i[1] == i[0]});
		end
		$display("test space one done");
		stop_test();
	end
endmodule
`default_nettype wire
